// >>> core/nwp_pkg.sv
// Package: constants for the NAND write-protect host guard
package nwp_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned PROT_SETUP_NS    = 100;
   localparam int unsigned PROT_SETUP_CYC   = (PROT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_US      = 1000;
   localparam int unsigned RECOVERY_CYC     = (RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OTP_PAGE_BYTES   = 2112;
   localparam logic [7:0]  STAT_IDLE_WP_HI  = 8'hE0;
   localparam logic [7:0]  STAT_IDLE_WP_LO  = 8'h60;
   localparam int unsigned STAT_READY_BIT   = 5;
   localparam int unsigned CNT_W            = 16;

   typedef enum logic [2:0] {
      NWP_POWERUP = 3'b000,
      NWP_IDLE    = 3'b001,
      NWP_SETUP   = 3'b010,
      NWP_ISSUE   = 3'b011,
      NWP_BUSY    = 3'b100
   } nwp_state_e;
endpackage

// >>> core/nwp_host_guard.sv
// Host-side write-protect sequencer for an asynchronous NAND device
`timescale 1ns/1ps
// Behaviour
// RQ1 - Device offers several OTP pages, each a full 2112-byte page.
// RQ2 - OTP area reached only by its own commands; host keeps ordinary ones apart.
// RQ3 - OTP bits read as one when shipped.
// RQ4 - Device refuses OTP erase, and OTP programming once protected.
// RQ5 - Low protect pin blocks program and erase; high permits them.
// RQ6 - Host sets protect pin a setup time before first command latch.
// RQ7 - Host holds protect pin steady until status ready bit reads one.
// RQ8 - Host waits recovery time after power-up before any command.
// RQ9 - Host keeps protect pin low during power ramps.
// RQ10 - Device suppresses all functions while supply is below threshold.
// RQ11 - Idle status reads E0h with protect high, 60h with it low.
// RQ12 - Blocked program or erase leaves array unchanged and returns ready.
module nwp_host_guard #(
   parameter int unsigned RECOVERY_CYCLES = nwp_pkg::RECOVERY_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       opReq,
   input  wire logic       opWrite,
   input  wire logic       opOtp,
   input  wire logic       opDone,
   input  wire logic       readyBusyN,
   input  wire logic [7:0] statusByte,
   input  wire logic       statusValid,
   output logic            opAck,
   output logic            cmdGo,
   output logic            cmdOtp,
   output logic            writeProtectN,
   output logic            hostReady,
   output logic            wpMismatch
);
   nwp_pkg::nwp_state_e          state_q, state_d;
   logic [nwp_pkg::CNT_W-1:0]   cnt_q, cnt_d;
   logic                        wp_q, wp_d;
   logic                        otp_q, otp_d;
   logic                        mis_q, mis_d;
   logic [7:0]                  expStat;

   // Idle status must mirror the pin we drive
   assign expStat = wp_q ? nwp_pkg::STAT_IDLE_WP_HI : nwp_pkg::STAT_IDLE_WP_LO; // RQ11

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      wp_d    = wp_q;
      otp_d   = otp_q;
      mis_d   = mis_q;
      unique case (state_q)
         nwp_pkg::NWP_POWERUP: begin
            wp_d = 1'b0; // RQ9
            if (cnt_q >= RECOVERY_CYCLES[nwp_pkg::CNT_W-1:0] - 16'h0001) begin // RQ8
               state_d = nwp_pkg::NWP_IDLE;
               cnt_d   = 16'h0000;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         nwp_pkg::NWP_IDLE: begin
            if (statusValid && readyBusyN) begin
               mis_d = (statusByte != expStat); // RQ11
            end
            if (opReq) begin
               otp_d = opOtp; // RQ2
               // Pin only moves here, never while an operation runs
               if (opWrite != wp_q) begin
                  wp_d    = opWrite; // RQ5
                  cnt_d   = 16'h0000;
                  state_d = nwp_pkg::NWP_SETUP;
               end else begin
                  state_d = nwp_pkg::NWP_ISSUE;
               end
            end
         end
         nwp_pkg::NWP_SETUP: begin
            if (cnt_q >= nwp_pkg::PROT_SETUP_CYC[nwp_pkg::CNT_W-1:0] - 16'h0001) begin // RQ6
               state_d = nwp_pkg::NWP_ISSUE;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         nwp_pkg::NWP_ISSUE: begin
            state_d = nwp_pkg::NWP_BUSY;
         end
         nwp_pkg::NWP_BUSY: begin
            // opDone with a valid status showing the ready bit ends the hold; a rejected command also lands here
            if (opDone && statusValid && statusByte[nwp_pkg::STAT_READY_BIT]) begin // RQ7 RQ12
               state_d = nwp_pkg::NWP_IDLE;
            end
         end
         default: begin
            state_d = nwp_pkg::NWP_POWERUP;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= nwp_pkg::NWP_POWERUP;
         cnt_q   <= 16'h0000;
         wp_q    <= 1'b0;
         otp_q   <= 1'b0;
         mis_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wp_q    <= wp_d;
         otp_q   <= otp_d;
         mis_q   <= mis_d;
      end
   end

   assign opAck         = (state_q == nwp_pkg::NWP_IDLE) && opReq;
   assign cmdGo         = (state_q == nwp_pkg::NWP_ISSUE);
   assign cmdOtp        = otp_q;
   assign writeProtectN = wp_q;
   assign hostReady     = (state_q == nwp_pkg::NWP_IDLE);
   assign wpMismatch    = mis_q;
endmodule

// >>> verification/nwp_guard_monitor.sv
// Assertion checker for the write-protect guard
`timescale 1ns/1ps
module nwp_guard_monitor #(
   parameter int unsigned RECOVERY_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic opWrite,
   input wire logic opOtp,
   input wire logic opAck,
   input wire logic cmdGo,
   input wire logic cmdOtp,
   input wire logic writeProtectN,
   input wire logic hostReady
);
   int unsigned upCnt_q, upCnt_d;
   always_comb upCnt_d = (upCnt_q < RECOVERY_CYCLES) ? upCnt_q + 1 : upCnt_q;
   always_ff @(posedge ref_clk or negedge rstn) if (!rstn) upCnt_q <= 0; else upCnt_q <= upCnt_d;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence taken; opAck; endsequence
   sequence goSoon; ##[1:2] cmdGo; endsequence
   chk_go_after_take: assert property (taken |-> goSoon) else $error("no start");
   chk_setup_held: assert property (cmdGo |-> $stable(writeProtectN)) else $error("no setup");
   chk_pin_frozen: assert property ($changed(writeProtectN) |-> $past(opAck)) else $error("pin moved");
   chk_pin_level: assert property (taken |=> writeProtectN == $past(opWrite)) else $error("pin level");
   chk_otp_select: assert property (taken |=> cmdOtp == $past(opOtp)) else $error("otp select");
   chk_recovery_wait: assert property (hostReady |-> upCnt_q == RECOVERY_CYCLES) else $error("early");
   chk_busy_refuse: assert property (cmdGo |=> !hostReady) else $error("not busy");
endmodule
bind nwp_host_guard nwp_guard_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) mon_u (.*);

// >>> verification/nwp_nand_model.sv
// Behavioural NAND device
`timescale 1ns/1ps
module nwp_nand_model #(
   parameter int unsigned OTP_PAGES = 4
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       cmdGo,
   input  wire logic       cmdOtp,
   input  wire logic       writeProtectN,
   input  wire logic [3:0] lat,
   output logic            opDone,
   output logic            readyBusyN,
   output logic            statusValid,
   output logic [7:0]      statusByte
);
   logic [4:0] busyCnt_q = 5'h00;
   logic       otpLock_q = 1'h0;
   // Whole pages, spare bytes included
   logic [7:0] otpMem [OTP_PAGES * nwp_pkg::OTP_PAGE_BYTES];
   // Shipped erased
   initial foreach (otpMem[j]) otpMem[j] = 8'hFF;
   // Reset stands for a supply below threshold: nothing starts
   // Blocked jobs end after one busy cycle, array untouched
   always @(posedge ref_clk or negedge rstn)
      if (!rstn) busyCnt_q <= 5'h00;
      else if (cmdGo) busyCnt_q <= (writeProtectN && !(cmdOtp && otpLock_q)) ? lat + 5'h02 : 5'h01;
      else if (busyCnt_q != 5'h00) busyCnt_q <= busyCnt_q - 5'h01;
   // Only the OTP command set reaches these pages; bits only ever clear, first write locks
   always @(posedge ref_clk)
      if (rstn && cmdGo && cmdOtp && writeProtectN && !otpLock_q) begin
         otpMem[lat] <= otpMem[lat] & 8'h0F;
         otpLock_q   <= 1'h1;
      end
   assign readyBusyN = busyCnt_q == 5'h00;
   assign opDone = readyBusyN;
   assign statusValid = 1'b1;
   assign statusByte = {writeProtectN, 1'b1, readyBusyN, 5'h00};
endmodule

// >>> verification/nwp_host_guard_bench.sv
// Random bench for the write-protect guard
`timescale 1ns/1ps
module nwp_host_guard_bench;
   logic ref_clk = 0, rstn = 0, opReq = 0, opWrite = 0, opOtp = 0, pin = 0;
   logic opDone, readyBusyN, statusValid, opAck, cmdGo, cmdOtp, writeProtectN, hostReady, wpMismatch;
   logic [7:0] statusByte;
   logic [3:0] lat = 4'h0;
   logic [15:0] seed = 16'h8516;
   int bad_count = 0, samples_checked = 0, k, i;
   always #50 ref_clk = ~ref_clk;
   nwp_host_guard #(.RECOVERY_CYCLES(8)) dut_u (.*);
   nwp_nand_model dev_u (.*);
   function automatic logic [15:0] xs(input logic [15:0] x);
      x ^= x << 7;
      x ^= x >> 9;
      return x ^ (x << 8);
   endfunction
   // Pin toggle costs one setup cycle
   function automatic int expLat(input logic p, w);
      return (p !== w) ? 2 : 1;
   endfunction
   task automatic chk(input logic a, b);
      samples_checked++;
      if (a !== b) begin
         bad_count++;
         $display("[FAIL] %0t mismatch", $time);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic op(input logic w, o);
      for (k = 0; k < 40 && hostReady !== 1; k++) @(negedge ref_clk);
      if (hostReady !== 1) begin
         chk(0, 1);
         results();
      end
      chk(wpMismatch, 0);
      @(posedge ref_clk);
      #1 opReq = 1; opWrite = w; opOtp = o; lat = seed[5:2];
      @(negedge ref_clk);
      chk(opAck, 1);
      k = 0;
      do begin @(negedge ref_clk); k++; end while (cmdGo !== 1 && k < 9);
      chk(k == expLat(pin, w), 1);
      if (cmdGo !== 1) results();
      chk(writeProtectN, w);
      chk(cmdOtp, o);
      chk(opAck, 0);
      pin = w;
      @(posedge ref_clk);
      #1 opReq = 0;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      #1 rstn = 1;
      repeat (4) @(negedge ref_clk);
      chk(hostReady, 0);
      for (i = 0; i < 24; i++) begin
         seed = xs(seed);
         op(i < 2 ? 1'b1 : seed[0], seed[1]);
      end
      results();
   end
endmodule
